// ---- src/ipwdt_params.svh ----
// Constants for the indexed port watchdog timer and its host controller
`ifndef IPWDT_PARAMS_SVH
`define IPWDT_PARAMS_SVH
`define IPWDT_PORT_INDEX    8'h2E
`define IPWDT_PORT_DATA     8'h2F
`define IPWDT_KEY_UNLOCK    8'h87
`define IPWDT_KEY_LOCK      8'hAA
`define IPWDT_IDX_LDEV      8'h07
`define IPWDT_IDX_ACTIVATE  8'h30
`define IPWDT_IDX_UNIT      8'hF5
`define IPWDT_IDX_COUNT     8'hF6
`define IPWDT_IDX_STROBE    8'hF7
`define IPWDT_LDEV_WDT      8'h08
`define IPWDT_ACT_ON        8'h01
`define IPWDT_UNIT_BIT      3
`define IPWDT_MOUSE_BIT     7
`define IPWDT_KBD_BIT       6
`define IPWDT_FORCE_BIT     5
`define IPWDT_STAT_BIT      4
`define IPWDT_CLK_HZ        50000000
`define IPWDT_TICK_S        1
`define IPWDT_TICK_CYCLES   (`IPWDT_CLK_HZ * `IPWDT_TICK_S)
`define IPWDT_SEC_PER_MIN   6'd60
`define IPWDT_AHB_CMD       8'h00
`define IPWDT_AHB_STATUS    8'h04
`define IPWDT_AHB_IRQ_STAT  8'h08
`define IPWDT_AHB_IRQ_CLR   8'h0C
`define IPWDT_AHB_IRQ_EN    8'h10
`define IPWDT_CMD_PORT_BIT  8
`define IPWDT_CMD_READ_BIT  9
`define IPWDT_IRQ_DONE_BIT  0
`define IPWDT_IRQ_TOUT_BIT  1
`endif

// ---- src/ipwdt_pkg.sv ----
// Types shared by both ends of the watchdog port link
package ipwdt_pkg;
  typedef logic [7:0] ipwdt_byte_t;
  typedef enum logic [1:0] {
    IPWDT_LOCKED,
    IPWDT_KEY1,
    IPWDT_OPEN
  } ipwdt_key_t;
  typedef enum logic [1:0] {
    IPWDT_H_IDLE,
    IPWDT_H_WAIT
  } ipwdt_host_st_t;
endpackage

// ---- src/ipwdt_if.sv ----
// I/O port link between host controller and watchdog device
`timescale 1ns/1ps
interface ipwdt_if;
  import ipwdt_pkg::*;
  ipwdt_byte_t port_addr;
  logic        wr_stb;
  logic        rd_stb;
  ipwdt_byte_t wdata;
  ipwdt_byte_t rdata;
  logic        rvalid;
  logic        expired;
  modport dev  (input port_addr, wr_stb, rd_stb, wdata, output rdata, rvalid, expired);
  modport host (output port_addr, wr_stb, rd_stb, wdata, input rdata, rvalid, expired);
endinterface

// ---- src/ipwdt_device.sv ----
// Watchdog device reached through an index/data port pair
//
// Function
// - Index at 2E, then data at 2F
// - Two 87 writes to 2E unlock
// - AA written to 2E locks again
// - Select 08 at index 07 for watchdog
// - 01 at index 30 enables; off after reset
// - F5 bit 3 picks seconds or minutes
// - F6 zero stops; 01..FF sets length
// - Each F6 write reloads and restarts counter
// - Expiry asserts the timeout output
// - F7 bit 7 lets mouse reload counter
// - F7 bit 6 lets keyboard reload counter
// - F7 bit 5 forces timeout, self clears; here only while 01 is at index 30
// - F7 bit 4 reads timeout status
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "ipwdt_params.svh"
module ipwdt_device #(
  parameter int TICK_CYCLES = `IPWDT_TICK_CYCLES
) (
  input  wire logic      REF_CLK,
  input  wire logic      RST,
  input  wire logic      MOUSE_ACT,
  input  wire logic      KBD_ACT,
  output logic           WDT_TIMEOUT,
  ipwdt_if.dev           LINK
);
  import ipwdt_pkg::*;

  // ****************************************
  // Activity pin synchronisers
  // ****************************************
  logic [2:0] mouse_sync_r;
  logic [2:0] kbd_sync_r;
  logic       mouse_lvl_r;
  logic       kbd_lvl_r;
  logic       mouse_evt;
  logic       kbd_evt;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mouse_sync_r <= 3'h0;
      kbd_sync_r   <= 3'h0;
    end else begin
      mouse_sync_r <= {mouse_sync_r[1:0], MOUSE_ACT};
      kbd_sync_r   <= {kbd_sync_r[1:0], KBD_ACT};
    end
  end

  // Level changes once second and third stage agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mouse_lvl_r <= 1'b0;
      kbd_lvl_r   <= 1'b0;
    end else begin
      if (mouse_sync_r[1] == mouse_sync_r[2]) begin
        mouse_lvl_r <= mouse_sync_r[2];
      end
      if (kbd_sync_r[1] == kbd_sync_r[2]) begin
        kbd_lvl_r <= kbd_sync_r[2];
      end
    end
  end

  assign mouse_evt = (mouse_sync_r[1] == mouse_sync_r[2]) && mouse_sync_r[2] && !mouse_lvl_r;
  assign kbd_evt   = (kbd_sync_r[1] == kbd_sync_r[2]) && kbd_sync_r[2] && !kbd_lvl_r;

  // ****************************************
  // Key sequence and index
  // ****************************************
  ipwdt_key_t  key_r;
  ipwdt_byte_t index_r;
  ipwdt_byte_t ldev_r;
  logic        idx_wr;
  logic        dat_wr;
  logic        wdt_wr;

  assign idx_wr = LINK.wr_stb && (LINK.port_addr == `IPWDT_PORT_INDEX);
  assign dat_wr = LINK.wr_stb && (LINK.port_addr == `IPWDT_PORT_DATA) && (key_r == IPWDT_OPEN);
  assign wdt_wr = dat_wr && (ldev_r == `IPWDT_LDEV_WDT);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      key_r <= IPWDT_LOCKED;
    end else if (idx_wr) begin
      if (LINK.wdata == `IPWDT_KEY_LOCK) begin
        key_r <= IPWDT_LOCKED;
      end else if (LINK.wdata == `IPWDT_KEY_UNLOCK) begin
        case (key_r)
          IPWDT_LOCKED: key_r <= IPWDT_KEY1;
          IPWDT_KEY1:   key_r <= IPWDT_OPEN;
          IPWDT_OPEN:   key_r <= IPWDT_OPEN;
          default:      key_r <= IPWDT_LOCKED;
        endcase
      end else if (key_r == IPWDT_KEY1) begin
        key_r <= IPWDT_LOCKED;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      index_r <= 8'h00;
    end else if (idx_wr && key_r == IPWDT_OPEN && LINK.wdata != `IPWDT_KEY_LOCK) begin
      index_r <= LINK.wdata;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ldev_r <= 8'h00;
    end else if (dat_wr && index_r == `IPWDT_IDX_LDEV) begin
      ldev_r <= LINK.wdata;
    end
  end

  // ****************************************
  // Watchdog registers
  // ****************************************
  logic        active_r;
  ipwdt_byte_t unit_r;
  ipwdt_byte_t reload_r;
  logic        mouse_en_r;
  logic        kbd_en_r;
  logic        status_r;
  logic        wr_unit;
  logic        wr_count;
  logic        wr_strobe;
  logic        force_to;
  logic        expire;

  assign wr_unit   = wdt_wr && index_r == `IPWDT_IDX_UNIT;
  assign wr_count  = wdt_wr && index_r == `IPWDT_IDX_COUNT;
  assign wr_strobe = wdt_wr && index_r == `IPWDT_IDX_STROBE;
  assign force_to  = wr_strobe && LINK.wdata[`IPWDT_FORCE_BIT] && active_r;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      active_r <= 1'b0;
    end else if (wdt_wr && index_r == `IPWDT_IDX_ACTIVATE) begin
      active_r <= (LINK.wdata == `IPWDT_ACT_ON);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      unit_r <= 8'h00;
    end else if (wr_unit) begin
      unit_r <= LINK.wdata;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      reload_r <= 8'h00;
    end else if (wr_count) begin
      reload_r <= LINK.wdata;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mouse_en_r <= 1'b0;
      kbd_en_r   <= 1'b0;
    end else if (wr_strobe) begin
      mouse_en_r <= LINK.wdata[`IPWDT_MOUSE_BIT];
      kbd_en_r   <= LINK.wdata[`IPWDT_KBD_BIT];
    end
  end

  // Set wins over a clearing write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      status_r <= 1'b0;
    end else if (expire || force_to) begin
      status_r <= 1'b1;
    end else if (wr_strobe && !LINK.wdata[`IPWDT_STAT_BIT]) begin
      status_r <= 1'b0;
    end
  end

  assign WDT_TIMEOUT  = status_r;
  assign LINK.expired = status_r;

  // ****************************************
  // Prescaler and countdown
  // ****************************************
  logic [$clog2(TICK_CYCLES)-1:0] presc_r;
  logic [5:0]                     sec_r;
  ipwdt_byte_t                    count_r;
  logic                           sec_tick;
  logic                           unit_tick;
  logic                           reload;

  assign sec_tick  = (presc_r == $bits(presc_r)'(TICK_CYCLES - 1));
  assign unit_tick = sec_tick && (!unit_r[`IPWDT_UNIT_BIT] || sec_r == `IPWDT_SEC_PER_MIN - 6'd1);
  assign reload    = wr_count || (mouse_evt && mouse_en_r) || (kbd_evt && kbd_en_r);
  assign expire    = active_r && !reload && unit_tick && count_r == 8'h01;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      presc_r <= '0;
    end else if (reload || sec_tick) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sec_r <= 6'h00;
    end else if (reload || unit_tick) begin
      sec_r <= 6'h00;
    end else if (sec_tick) begin
      sec_r <= sec_r + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      count_r <= 8'h00;
    end else if (wr_count) begin
      count_r <= LINK.wdata;
    end else if (reload) begin
      count_r <= reload_r;
    end else if (active_r && unit_tick && count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end

  // ****************************************
  // Data port reads
  // ****************************************
  logic dat_rd;

  assign dat_rd = LINK.rd_stb && (LINK.port_addr == `IPWDT_PORT_DATA);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LINK.rvalid <= 1'b0;
    end else begin
      LINK.rvalid <= LINK.rd_stb;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LINK.rdata <= 8'h00;
    end else if (LINK.rd_stb) begin
      LINK.rdata <= 8'h00;
      if (!dat_rd || key_r != IPWDT_OPEN) begin
        LINK.rdata <= 8'h00;
      end else if (index_r == `IPWDT_IDX_LDEV) begin
        LINK.rdata <= ldev_r;
      end else if (ldev_r == `IPWDT_LDEV_WDT) begin
        case (index_r)
          `IPWDT_IDX_ACTIVATE: LINK.rdata <= {7'h00, active_r};
          `IPWDT_IDX_UNIT:     LINK.rdata <= unit_r;
          `IPWDT_IDX_COUNT:    LINK.rdata <= count_r;
          `IPWDT_IDX_STROBE:   LINK.rdata <= {mouse_en_r, kbd_en_r, 1'b0, status_r, 4'h0};
          default:             LINK.rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // ipwdt_device

// ---- src/ipwdt_host.sv ----
// Host controller: AHB-Lite registers driving the I/O port link
`timescale 1ns/1ps
`include "ipwdt_params.svh"
module ipwdt_host (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             IRQ,
  ipwdt_if.host            LINK
);
  import ipwdt_pkg::*;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic       dp_wr_r;
  logic [7:0] dp_addr_r;
  logic       cmd_wr;
  logic       clr_wr;
  logic       en_wr;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (HREADY) begin
      dp_wr_r   <= HSEL && HTRANS[1] && HWRITE;
      dp_addr_r <= HADDR[7:0];
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign cmd_wr    = dp_wr_r && dp_addr_r == `IPWDT_AHB_CMD;
  assign clr_wr    = dp_wr_r && dp_addr_r == `IPWDT_AHB_IRQ_CLR;
  assign en_wr     = dp_wr_r && dp_addr_r == `IPWDT_AHB_IRQ_EN;

  // ****************************************
  // Port cycle sequencer
  // ****************************************
  ipwdt_host_st_t st_r;
  ipwdt_byte_t    rd_data_r;
  logic           done;

  assign done = (st_r == IPWDT_H_WAIT) && LINK.rvalid;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r         <= IPWDT_H_IDLE;
      LINK.wr_stb  <= 1'b0;
      LINK.rd_stb  <= 1'b0;
      LINK.port_addr <= 8'h00;
      LINK.wdata   <= 8'h00;
    end else begin
      LINK.wr_stb <= 1'b0;
      LINK.rd_stb <= 1'b0;
      case (st_r)
        IPWDT_H_IDLE: begin
          if (cmd_wr) begin
            LINK.port_addr <= HWDATA[`IPWDT_CMD_PORT_BIT] ? `IPWDT_PORT_DATA : `IPWDT_PORT_INDEX;
            LINK.wdata     <= HWDATA[7:0];
            LINK.wr_stb    <= !HWDATA[`IPWDT_CMD_READ_BIT];
            LINK.rd_stb    <= HWDATA[`IPWDT_CMD_READ_BIT];
            if (HWDATA[`IPWDT_CMD_READ_BIT]) begin
              st_r <= IPWDT_H_WAIT;
            end
          end
        end
        IPWDT_H_WAIT: begin
          if (LINK.rvalid) begin
            st_r <= IPWDT_H_IDLE;
          end
        end
        default: st_r <= IPWDT_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_data_r <= 8'h00;
    end else if (done) begin
      rd_data_r <= LINK.rdata;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic       exp_d_r;
  logic [1:0] irq_set;

  assign irq_set = {LINK.expired && !exp_d_r, done || (cmd_wr && st_r == IPWDT_H_IDLE && !HWDATA[`IPWDT_CMD_READ_BIT])};

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      exp_d_r <= 1'b0;
    end else begin
      exp_d_r <= LINK.expired;
    end
  end

  // Set wins over clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(clr_wr ? HWDATA[1:0] : 2'h0)) | irq_set;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_en_r <= 2'h0;
    end else if (en_wr) begin
      irq_en_r <= HWDATA[1:0];
    end
  end

  assign IRQ = |(irq_stat_r & irq_en_r);

  always_comb begin
    HRDATA = 32'h0000_0000;
    case (dp_addr_r)
      `IPWDT_AHB_STATUS:   HRDATA = {16'h0000, rd_data_r, 6'h00, LINK.expired, st_r != IPWDT_H_IDLE};
      `IPWDT_AHB_IRQ_STAT: HRDATA = {30'h0000_0000, irq_stat_r};
      `IPWDT_AHB_IRQ_EN:   HRDATA = {30'h0000_0000, irq_en_r};
      default:             HRDATA = 32'h0000_0000;
    endcase
  end

endmodule // ipwdt_host

// ---- verification/ipwdt_checker.sv ----
// Assertions on the port link between host controller and watchdog device
`timescale 1ns/1ps
`include "ipwdt_params.svh"
module ipwdt_checker (
  input wire logic                 REF_CLK,
  input wire logic                 RST,
  input wire ipwdt_pkg::ipwdt_byte_t port_addr,
  input wire logic                 wr_stb,
  input wire logic                 rd_stb,
  input wire ipwdt_pkg::ipwdt_byte_t wdata,
  input wire ipwdt_pkg::ipwdt_byte_t rdata,
  input wire logic                 rvalid,
  input wire logic                 expired
);
  import ipwdt_pkg::*;
  ipwdt_key_t  key_r;
  ipwdt_byte_t idx_r;
  ipwdt_byte_t ldev_r;
  logic        act_r;
  logic        open_w;
  logic        wdt_w;
  assign open_w = (key_r == IPWDT_OPEN);
  assign wdt_w  = wr_stb && port_addr == `IPWDT_PORT_DATA && open_w && ldev_r == `IPWDT_LDEV_WDT;
  // ****************************************
  // Shadow of the key, index and selection
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      key_r <= IPWDT_LOCKED;
    end else if (wr_stb && port_addr == `IPWDT_PORT_INDEX) begin
      if (open_w) begin
        key_r <= (wdata == `IPWDT_KEY_LOCK) ? IPWDT_LOCKED : IPWDT_OPEN;
      end else begin
        key_r <= (wdata != `IPWDT_KEY_UNLOCK) ? IPWDT_LOCKED : (key_r == IPWDT_KEY1) ? IPWDT_OPEN : IPWDT_KEY1;
      end
    end
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      idx_r <= 8'h00;
    end else if (wr_stb && port_addr == `IPWDT_PORT_INDEX && open_w && wdata != `IPWDT_KEY_LOCK) begin
      idx_r <= wdata;
    end
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ldev_r <= 8'h00;
      act_r  <= 1'b0;
    end else if (wr_stb && port_addr == `IPWDT_PORT_DATA && open_w) begin
      if (idx_r == `IPWDT_IDX_LDEV) ldev_r <= wdata;
      if (wdt_w && idx_r == `IPWDT_IDX_ACTIVATE) act_r <= (wdata == `IPWDT_ACT_ON);
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ****************************************
  // Properties
  // ****************************************
  property p_rd_answer; rd_stb |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered");
  property p_rv_cause; rvalid |-> $past(rd_stb); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without read strobe");
  property p_stb_pulse; (wr_stb || rd_stb) |=> !(wr_stb || rd_stb); endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe longer than one cycle");
  property p_locked_zero; rd_stb && !open_w |=> rvalid && rdata == 8'h00; endproperty
  a_locked_zero: assert property (p_locked_zero) else $error("locked read not zero");
  property p_force; wdt_w && idx_r == `IPWDT_IDX_STROBE && act_r && wdata[`IPWDT_FORCE_BIT] |-> ##[1:2] expired; endproperty
  a_force: assert property (p_force) else $error("forced timeout missing");
  property p_clear_cause;
    $fell(expired) |-> $past(wdt_w && idx_r == `IPWDT_IDX_STROBE && !wdata[`IPWDT_STAT_BIT]);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("status cleared without write");
  property p_need_active; $rose(expired) |-> $past(act_r); endproperty
  a_need_active: assert property (p_need_active) else $error("timeout while inactive");
  property p_stat_read;
    rd_stb && port_addr == `IPWDT_PORT_DATA && open_w && ldev_r == `IPWDT_LDEV_WDT && idx_r == `IPWDT_IDX_STROBE
      |=> rdata[`IPWDT_STAT_BIT] == $past(expired) && !rdata[`IPWDT_FORCE_BIT];
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status bit read wrong");
endmodule // ipwdt_checker

// ---- verification/indexed_port_watchdog_timer_test.sv ----
// Self-checking bench joining the host controller and the watchdog device
`timescale 1ns/1ps
`include "ipwdt_params.svh"
`define CHK_EQ(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module indexed_port_watchdog_timer_test;
  import ipwdt_pkg::*;
  localparam int TICK = 10;
  localparam ipwdt_byte_t I_CNT = `IPWDT_IDX_COUNT;
  localparam ipwdt_byte_t I_STB = `IPWDT_IDX_STROBE;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        IRQ;
  logic        MOUSE_ACT = 1'b0;
  logic        KBD_ACT = 1'b0;
  logic        WDT_TIMEOUT;
  logic [31:0] rd;
  ipwdt_byte_t b;
  int          num_errors = 0;
  int          cmp_count = 0;
  ipwdt_if link ();
  ipwdt_host u_ipwdt_host (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .LINK(link));
  ipwdt_device #(.TICK_CYCLES(TICK)) u_ipwdt_device (.REF_CLK(REF_CLK), .RST(RST), .MOUSE_ACT(MOUSE_ACT),
    .KBD_ACT(KBD_ACT), .WDT_TIMEOUT(WDT_TIMEOUT), .LINK(link));
  ipwdt_checker u_ipwdt_checker (.REF_CLK(REF_CLK), .RST(RST), .port_addr(link.port_addr),
    .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid), .expired(link.expired));
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end
  // ****************************************
  // Bus and port tasks
  // ****************************************
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    report_and_stop();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    int k;
    logic r;
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= wr;
    for (n = 0; n < 2; n++) begin
      r = 1'b0;
      for (k = 0; k < 20 && r !== 1'b1; k++) begin
        @(negedge REF_CLK);
        r = HREADYOUT;
        q = HRDATA;
        @(posedge REF_CLK);
      end
      if (r !== 1'b1) hang();
      if (n == 0) begin
        HTRANS <= 2'h0;
        HWDATA <= d;
      end
    end
  endtask
  task automatic port(input logic dp, input logic rdn, input logic [7:0] v, output logic [7:0] q);
    logic [31:0] s;
    int n;
    ahb(1'b1, `IPWDT_AHB_CMD, {22'h0, rdn, dp, v}, s);
    for (n = 0; n < 20; n++) begin
      ahb(1'b0, `IPWDT_AHB_STATUS, 32'h0, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 20) hang();
    q = s[15:8];
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
    logic [7:0] q;
    port(1'b0, 1'b0, i, q);
    port(1'b1, 1'b0, v, q);
  endtask
  task automatic chk_reg(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    port(1'b0, 1'b0, i, q);
    port(1'b1, 1'b1, 8'h00, q);
    `CHK_EQ(q, e)
  endtask
  task automatic unlock();
    port(1'b0, 1'b0, `IPWDT_KEY_UNLOCK, b);
    port(1'b0, 1'b0, `IPWDT_KEY_UNLOCK, b);
  endtask
  task automatic wait_to(input int n);
    int i;
    for (i = 0; i < n && WDT_TIMEOUT !== 1'b1; i++) cyc(1);
    if (WDT_TIMEOUT !== 1'b1) hang();
  endtask
  task automatic pulse(input int m);
    @(posedge REF_CLK);
    if (m == 0) MOUSE_ACT <= 1'b1;
    else KBD_ACT <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    MOUSE_ACT <= 1'b0;
    KBD_ACT <= 1'b0;
    cyc(1);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    ahb(1'b0, `IPWDT_AHB_STATUS, 32'h0, rd);
    `CHK_EQ(rd, 32'h0)
    ahb(1'b0, 8'h20, 32'h0, rd);
    `CHK_EQ(rd, 32'h0)
    `CHK_EQ(HRESP, 1'b0)
    reg_wr(I_CNT, 8'h02);
    unlock();
    reg_wr(`IPWDT_IDX_LDEV, `IPWDT_LDEV_WDT);
    chk_reg(I_CNT, 8'h00);
    chk_reg(I_STB, 8'h00);
    chk_reg(`IPWDT_IDX_UNIT, 8'h00);
    reg_wr(I_CNT, 8'h03);
    cyc(60);
    `CHK_EQ(WDT_TIMEOUT, 1'b0)
    chk_reg(I_CNT, 8'h03);
    reg_wr(`IPWDT_IDX_ACTIVATE, `IPWDT_ACT_ON);
    reg_wr(I_CNT, 8'h03);
    cyc(18);
    `CHK_EQ(WDT_TIMEOUT, 1'b0)
    wait_to(40);
    chk_reg(I_STB, 8'h10);
    ahb(1'b0, `IPWDT_AHB_STATUS, 32'h0, rd);
    `CHK_EQ(rd[1], 1'b1)
    reg_wr(I_CNT, 8'h00);
    reg_wr(I_STB, 8'h00);
    cyc(100);
    `CHK_EQ(WDT_TIMEOUT, 1'b0)
    reg_wr(I_STB, 8'h20);
    cyc(2);
    `CHK_EQ(WDT_TIMEOUT, 1'b1)
    chk_reg(I_STB, 8'h10);
    reg_wr(I_STB, 8'hC0);
    chk_reg(I_STB, 8'hC0);
    reg_wr(I_CNT, 8'h03);
    for (int m = 0; m < 6; m++) begin
      cyc(14);
      pulse(m % 2);
    end
    `CHK_EQ(WDT_TIMEOUT, 1'b0)
    wait_to(50);
    reg_wr(I_STB, 8'h00);
    reg_wr(`IPWDT_IDX_UNIT, 8'h08);
    chk_reg(`IPWDT_IDX_UNIT, 8'h08);
    reg_wr(I_CNT, 8'h01);
    cyc(560);
    `CHK_EQ(WDT_TIMEOUT, 1'b0)
    wait_to(80);
    port(1'b0, 1'b0, I_STB, b);
    port(1'b0, 1'b0, `IPWDT_KEY_LOCK, b);
    chk_reg(I_STB, 8'h00);
    port(1'b1, 1'b0, 8'h00, b);
    unlock();
    chk_reg(I_STB, 8'h10);
    ahb(1'b0, `IPWDT_AHB_IRQ_STAT, 32'h0, rd);
    `CHK_EQ(rd[1], 1'b1)
    ahb(1'b1, `IPWDT_AHB_IRQ_EN, 32'h0, rd);
    cyc(1);
    `CHK_EQ(IRQ, 1'b0)
    ahb(1'b1, `IPWDT_AHB_IRQ_EN, 32'h2, rd);
    cyc(1);
    `CHK_EQ(IRQ, 1'b1)
    ahb(1'b0, `IPWDT_AHB_IRQ_EN, 32'h0, rd);
    `CHK_EQ(rd, 32'h2)
    ahb(1'b1, `IPWDT_AHB_IRQ_CLR, 32'h3, rd);
    cyc(1);
    `CHK_EQ(IRQ, 1'b0)
    ahb(1'b0, `IPWDT_AHB_IRQ_STAT, 32'h0, rd);
    `CHK_EQ(rd[1], 1'b0)
    report_and_stop();
  end
endmodule // indexed_port_watchdog_timer_test
